// >>> line_ctrl_pkg.sv
// shared constants for the line-control serial port and driver block
package line_ctrl_pkg;
   localparam int CMD_BITS    = 8;
   localparam int FRAME_BITS  = 16;
   localparam int ADDR_W      = 7;
   localparam int DATA_W      = 8;
   localparam int CNT_W       = 5;

   // command byte: bit 7 is read (1) or write (0), bits 6..0 the address
   localparam int CMD_RD_POS  = 7;

   // internal register addresses on the serial port
   localparam logic [6:0] ADDR_DRIVE_A = 7'h00;
   localparam logic [6:0] ADDR_DRIVE_B = 7'h01;
   localparam logic [6:0] ADDR_PENDING = 7'h02;
   localparam logic [6:0] ADDR_MASK    = 7'h03;
   localparam logic [6:0] ADDR_EVENTS  = 7'h04;
   localparam logic [6:0] ADDR_ID      = 7'h05;

   // drive register field positions
   localparam int DRV_BATTERY = 0;
   localparam int DRV_AUX     = 1;
   localparam int DRV_RING    = 2;
   localparam int DRV_TEST1   = 3;
   localparam int DRV_TEST2   = 4;
   localparam int DRV_FIELDS  = 5;

   // values after reset, and the value read from an unmapped address
   localparam logic [7:0] DRIVE_RESET   = 8'h00;
   localparam logic [7:0] PENDING_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET    = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_CMD  = 2'b01,
      PH_DATA = 2'b10,
      PH_THRU = 2'b11
   } phase_t;
endpackage

// >>> serial_frame_if.sv
// carrier between the serial engine and the register side
`timescale 1ns/10ps
interface serial_frame_if;
   import line_ctrl_pkg::*;
   logic              active;
   logic              wrPulse;
   logic              rdFlag;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wrData;
   logic [DATA_W-1:0] rdData;
   logic              dataOutBit;
   logic              chainBit;

   modport engine (output active, output wrPulse, output rdFlag, output addr,
                   output wrData, output dataOutBit, output chainBit, input rdData);
   modport regs   (input active, input wrPulse, input rdFlag, input addr,
                   input wrData, output rdData, input dataOutBit, input chainBit);
endinterface

// >>> serial_frame_engine.sv
// serial frame engine: edge finding on the sampled bit clock, shifting
`timescale 1ns/10ps
module serial_frame_engine
   import line_ctrl_pkg::*;
(
   input  logic               clk,
   input  logic               reset,
   input  logic               selectSync,
   input  logic               bitClkSync,
   input  logic               dataInSync,
   serial_frame_if.engine     frame
);
   phase_t            phase_r;
   logic              bitClkPrev_r;
   logic [CNT_W-1:0]  bitCnt_r;
   logic [DATA_W-1:0] inShift_r;
   logic [DATA_W-1:0] outShift_r;
   logic [ADDR_W-1:0] addr_r;
   logic              rdFlag_r;
   logic              wrPulse_r;
   logic              rise;
   logic              fall;
   logic [DATA_W-1:0] inNext;

   // R1: while deselected the bit clock and data are ignored
   assign rise   = selectSync & bitClkSync & ~bitClkPrev_r;
   assign fall   = selectSync & ~bitClkSync & bitClkPrev_r;
   assign inNext = {inShift_r[DATA_W-2:0], dataInSync};

   always_ff @(posedge clk) begin
      if (reset) begin
         bitClkPrev_r <= 1'b0;
      end else begin
         bitClkPrev_r <= bitClkSync;
      end
   end

   // R2: bits captured on rising bit-clock edges only
   always_ff @(posedge clk) begin
      if (reset || !selectSync) begin
         phase_r   <= PH_IDLE;
         bitCnt_r  <= '0;
         inShift_r <= '0;
      end else if (rise) begin
         inShift_r <= inNext;
         unique case (phase_r)
            PH_IDLE: begin
               phase_r  <= PH_CMD;
               bitCnt_r <= CNT_W'(1);
            end
            PH_CMD: begin
               bitCnt_r <= bitCnt_r + CNT_W'(1);
               if (bitCnt_r == CNT_W'(CMD_BITS - 1)) begin
                  phase_r <= PH_DATA;
               end
            end
            PH_DATA: begin
               bitCnt_r <= bitCnt_r + CNT_W'(1);
               if (bitCnt_r == CNT_W'(FRAME_BITS - 1)) begin
                  phase_r <= PH_THRU;
               end
            end
            PH_THRU: begin
               bitCnt_r <= bitCnt_r;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         addr_r    <= '0;
         rdFlag_r  <= 1'b0;
         wrPulse_r <= 1'b0;
      end else begin
         wrPulse_r <= 1'b0;
         if (rise && phase_r == PH_CMD && bitCnt_r == CNT_W'(CMD_BITS - 1)) begin
            addr_r   <= inNext[ADDR_W-1:0];
            rdFlag_r <= inNext[CMD_RD_POS];
         end
         if (rise && phase_r == PH_DATA && bitCnt_r == CNT_W'(FRAME_BITS - 1)) begin
            wrPulse_r <= ~rdFlag_r;
         end
      end
   end

   // R2: output data moves on falling bit-clock edges, msb first
   always_ff @(posedge clk) begin
      if (reset || !selectSync) begin
         outShift_r <= '0;
      end else if (fall) begin
         if (phase_r == PH_DATA && bitCnt_r == CNT_W'(CMD_BITS) && rdFlag_r) begin
            outShift_r <= frame.rdData;
         end else begin
            outShift_r <= {outShift_r[DATA_W-2:0], 1'b0};
         end
      end
   end

   assign frame.active   = selectSync;
   assign frame.wrPulse  = wrPulse_r;
   assign frame.rdFlag   = rdFlag_r;
   assign frame.addr     = addr_r;
   assign frame.wrData   = inShift_r;
   assign frame.dataOutBit = outShift_r[DATA_W-1];
   // R3: after its own frame the device hands data on down the chain
   // R4: chain idles high outside the pass-through phase
   assign frame.chainBit = (phase_r == PH_THRU) ? dataInSync : 1'b1;
endmodule

// >>> line_ctrl_top.sv
// serial control port, interrupt line and per-channel drivers
// Contract
// R1: deselected port ignores clock and data; data output floats
// R2: serial bit clock alone times capture and output shifting
// R3: chain output passes serial input on to the next device
// R4: chain output sits high whenever the port is idle
// R5: active-low reset pin returns all control registers to defaults
// R6: interrupt is open-drain, maskable, shareable as wired-OR
// R7: each channel drives a battery-select output
// R8: internal-ringing build offers a general-purpose output per channel
// R9: external-ringer build drives a ring relay output per channel
// R10: each channel drives two test relay outputs
// R11: interrupt pulled low while any unmasked event is pending
// R12: driver outputs follow control bits, inactive after reset
`timescale 1ns/10ps
module line_ctrl_top
   import line_ctrl_pkg::*;
#(
   parameter int         NUM_CH        = 2,
   parameter int         NUM_EVENTS    = 8,
   parameter bit         RING_INTERNAL = 1'b1,
   // arbitrary identification value
   parameter logic [7:0] DEVICE_TAG    = 8'h5A
)(
   input  logic                  clk,
   input  logic                  reset,
   input  logic                  resetPin_n,
   input  logic                  select_n,
   input  logic                  bitClk,
   input  logic                  serial_data_in,
   output logic                  serial_data_out,
   output logic                  serialDataOutOe,
   output logic                  serial_chain_out,
   output logic                  irqOut_n,
   output logic                  irqOe,
   input  logic [NUM_EVENTS-1:0] eventIn,
   output logic [NUM_CH-1:0]     battery_choice_out,
   output logic [NUM_CH-1:0]     aux_drive_out,
   output logic [NUM_CH-1:0]     ring_relay_drive,
   output logic [NUM_CH-1:0]     test_relay_drive_one,
   output logic [NUM_CH-1:0]     test_relay_drive_two
);
   serial_frame_if frame ();

   logic [1:0]            selMeta_r;
   logic [1:0]            clkMeta_r;
   logic [1:0]            dataMeta_r;
   logic [1:0]            rstMeta_r;
   logic                  ctrlClear;
   logic                  wrMask;
   logic                  wrPending;
   logic [7:0]            drive_r [NUM_CH];
   logic [NUM_EVENTS-1:0] pending_r;
   logic [NUM_EVENTS-1:0] mask_r;
   logic [NUM_EVENTS-1:0] pending_nxt;
   logic [NUM_EVENTS-1:0] clearBits;
   logic [DATA_W-1:0]     rdData;

   // pins cross into the clock domain through two flops each
   always_ff @(posedge clk) begin
      if (reset) begin
         selMeta_r  <= 2'h3;
         clkMeta_r  <= 2'h0;
         dataMeta_r <= 2'h3;
         // starts asserted so a core reset also clears engine and registers
         rstMeta_r  <= 2'h0;
      end else begin
         selMeta_r  <= {selMeta_r[0], select_n};
         clkMeta_r  <= {clkMeta_r[0], bitClk};
         dataMeta_r <= {dataMeta_r[0], serial_data_in};
         rstMeta_r  <= {rstMeta_r[0], resetPin_n};
      end
   end

   // R5: pin reset clears control registers like the core reset
   assign ctrlClear = reset | ~rstMeta_r[1];

   serial_frame_engine u_engine (
      .clk        (clk),
      .reset      (ctrlClear),
      .selectSync (~selMeta_r[1]),
      .bitClkSync (clkMeta_r[1]),
      .dataInSync (dataMeta_r[1]),
      .frame      (frame)
   );

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
      hit = (a == r);
   endfunction

   // a write only counts when a whole frame named this address
   function automatic logic wrHit(input logic              pulse,
                                  input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] r);
      wrHit = pulse && hit(a, r);
   endfunction

   // channel registers sit at consecutive addresses from the first one
   function automatic logic [ADDR_W-1:0] driveAddr(input int c);
      driveAddr = ADDR_DRIVE_A + ADDR_W'(c);
   endfunction

   assign wrMask    = wrHit(frame.wrPulse, frame.addr, ADDR_MASK);
   assign wrPending = wrHit(frame.wrPulse, frame.addr, ADDR_PENDING);

   // R12: per-channel drive registers written over the serial port
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_drive
         always_ff @(posedge clk) begin
            if (ctrlClear) begin
               drive_r[ch] <= DRIVE_RESET;
            end else if (wrHit(frame.wrPulse, frame.addr, driveAddr(ch))) begin
               drive_r[ch] <= frame.wrData;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (ctrlClear) begin
         mask_r <= MASK_RESET[NUM_EVENTS-1:0];
      end else if (wrMask) begin
         mask_r <= frame.wrData[NUM_EVENTS-1:0];
      end
   end

   // write one to clear; a new event in the same cycle wins
   always_comb begin
      clearBits = '0;
      if (wrPending) begin
         clearBits = frame.wrData[NUM_EVENTS-1:0];
      end
      pending_nxt = (pending_r & ~clearBits) | eventIn;
   end

   always_ff @(posedge clk) begin
      if (ctrlClear) begin
         pending_r <= PENDING_RESET[NUM_EVENTS-1:0];
      end else begin
         pending_r <= pending_nxt;
      end
   end

   // read data decodes the live address, loaded on the next fall
   // bits above the event count read back as zero
   always_comb begin
      rdData = UNMAPPED_READ;
      if (hit(frame.addr, ADDR_PENDING)) begin
         rdData[NUM_EVENTS-1:0] = pending_r;
      end else if (hit(frame.addr, ADDR_MASK)) begin
         rdData[NUM_EVENTS-1:0] = mask_r;
      end else if (hit(frame.addr, ADDR_EVENTS)) begin
         rdData[NUM_EVENTS-1:0] = pending_r & mask_r;
      end else if (hit(frame.addr, ADDR_ID)) begin
         rdData = DEVICE_TAG;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (hit(frame.addr, driveAddr(i))) begin
               rdData = drive_r[i];
            end
         end
      end
   end
   assign frame.rdData = rdData;

   // serial outputs registered so the pins come straight from flops
   always_ff @(posedge clk) begin
      if (ctrlClear) begin
         serial_data_out  <= 1'b0;
         serialDataOutOe  <= 1'b0;
         // chain idles high even while the registers are held clear
         serial_chain_out <= 1'b1;
      end else begin
         serial_data_out  <= frame.dataOutBit;
         // R1: data output enabled only while selected
         serialDataOutOe  <= frame.active;
         // R3: chain follows serial input once this frame is consumed
         // R4: held high when idle
         serial_chain_out <= frame.chainBit;
      end
   end

   // R6: open drain, the pin only ever pulls low
   // R11: pulled while any unmasked event is pending
   always_ff @(posedge clk) begin
      if (ctrlClear) begin
         irqOut_n <= 1'b0;
         irqOe    <= 1'b0;
      end else begin
         // never driven high; the shared wire's pullup gives the high level
         irqOut_n <= 1'b0;
         irqOe    <= |(pending_nxt & mask_r);
      end
   end

   // unused variant outputs stay low so no relay coil is energised
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_out
         always_ff @(posedge clk) begin
            if (ctrlClear) begin
               battery_choice_out[ch]   <= 1'b0;
               aux_drive_out[ch]        <= 1'b0;
               ring_relay_drive[ch]     <= 1'b0;
               test_relay_drive_one[ch] <= 1'b0;
               test_relay_drive_two[ch] <= 1'b0;
            end else begin
               // R7: battery choice per channel
               battery_choice_out[ch]   <= drive_r[ch][DRV_BATTERY];
               // R8: general-purpose drive on the internal-ringing build
               aux_drive_out[ch]        <= RING_INTERNAL & drive_r[ch][DRV_AUX];
               // R9: ring relay on the external-ringer build
               ring_relay_drive[ch]     <= ~RING_INTERNAL & drive_r[ch][DRV_RING];
               // R10: two test relay drivers
               test_relay_drive_one[ch] <= drive_r[ch][DRV_TEST1];
               test_relay_drive_two[ch] <= drive_r[ch][DRV_TEST2];
            end
         end
      end
   endgenerate
endmodule

// >>> line_ctrl_top_props.sv
// port-level property checker for the line-control top
`timescale 1ns/10ps
module line_ctrl_top_props #(
   parameter int NUM_CH        = 2,
   parameter bit RING_INTERNAL = 1'b1
)(
   input logic              clk,
   input logic              reset,
   input logic              resetPin_n,
   input logic              select_n,
   input logic              serial_data_out,
   input logic              serialDataOutOe,
   input logic              serial_chain_out,
   input logic              irqOut_n,
   input logic              irqOe,
   input logic [NUM_CH-1:0] battery_choice_out,
   input logic [NUM_CH-1:0] aux_drive_out,
   input logic [NUM_CH-1:0] ring_relay_drive,
   input logic [NUM_CH-1:0] test_relay_drive_one
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // long enough to cover both synchroniser stages
   sequence quietPort;
      (select_n && resetPin_n)[*8];
   endsequence
   sequence selHeld;
      (!select_n && resetPin_n)[*5];
   endsequence
   deselOe_a: assert property (select_n[*5] |=> !serialDataOutOe)
      else $error("data output enabled while deselected");
   selOe_a: assert property (selHeld |=> serialDataOutOe)
      else $error("data output not enabled while selected");
   outQuiet_a: assert property (!serialDataOutOe[*3] |-> !serial_data_out)
      else $error("data output value while disabled");
   chainIdle_a: assert property (select_n[*5] |=> serial_chain_out)
      else $error("chain output low while idle");
   irqDrive_a: assert property (irqOe |-> !irqOut_n)
      else $error("interrupt driven high");
   ringVariant_a: assert property (RING_INTERNAL ? ring_relay_drive == '0 : aux_drive_out == '0)
      else $error("output of the other variant active");
   pinReset_a: assert property ((!resetPin_n)[*5] |=> battery_choice_out == '0 &&
      test_relay_drive_one == '0 && !irqOe && serial_chain_out)
      else $error("pin reset left state active");
   driveHold_a: assert property (quietPort |=> $stable(battery_choice_out) &&
      $stable(test_relay_drive_one))
      else $error("drivers moved without a frame");
   irqHold_a: assert property (quietPort ##0 irqOe |=> irqOe)
      else $error("interrupt released without a clear");
endmodule
bind line_ctrl_top line_ctrl_top_props #(.NUM_CH(NUM_CH), .RING_INTERNAL(RING_INTERNAL)) props (
   .clk, .reset, .resetPin_n, .select_n, .serial_data_out, .serialDataOutOe,
   .serial_chain_out, .irqOut_n, .irqOe, .battery_choice_out, .aux_drive_out,
   .ring_relay_drive, .test_relay_drive_one);

// >>> host_serial_model.sv
// host controller model driving the serial control port
`timescale 1ns/10ps
module host_serial_model (
   input  logic clk,
   input  logic dataOutPin,
   input  logic chainPin,
   output logic select_n,
   output logic bitClk,
   output logic serial_data_in
);
   logic [23:0] chainSeen;
   logic [7:0]  rdSeen;
   initial begin
      select_n = 1'b1;
      bitClk = 1'b0;
      serial_data_in = 1'b1;
   end
   task automatic waitN(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic frame(input int n, input logic [23:0] tx);
      select_n = 1'b0;
      waitN(3);
      for (int i = 0; i < n; i++) begin
         serial_data_in = tx[23-i];
         waitN(4);
         bitClk = 1'b1;
         waitN(4);
         if (i >= 8 && i < 16) rdSeen = {rdSeen[6:0], dataOutPin};
         chainSeen = {chainSeen[22:0], chainPin};
         bitClk = 1'b0;
      end
      waitN(8);
      select_n = 1'b1;
      serial_data_in = ~serial_data_in;
      waitN(8);
   endtask
   task automatic stray(input int n, input logic [23:0] tx);
      for (int i = 0; i < n; i++) begin
         serial_data_in = tx[23-i];
         waitN(4);
         bitClk = 1'b1;
         waitN(4);
         bitClk = 1'b0;
      end
      waitN(8);
   endtask
endmodule

// >>> test_line_ctrl_top.sv
// self-checking bench for the line-control top
`timescale 1ns/10ps
module test_line_ctrl_top;
   import line_ctrl_pkg::*;
   logic       clk, reset, resetPin_n, select_n, bitClk, serial_data_in;
   logic       serial_data_out, serialDataOutOe, serial_chain_out, irqOut_n, irqOe;
   logic [7:0] eventIn, rdv;
   logic [1:0] battery_choice_out, aux_drive_out, ring_relay_drive, aux2, ring2;
   logic [1:0] test_relay_drive_one, test_relay_drive_two;
   logic [15:0] outs;
   int          n_fail, check_count;
   tri1         irqWire;
   wire         dataOutPin = serialDataOutOe ? serial_data_out : 1'bz;
   assign irqWire = irqOe ? irqOut_n : 1'bz;
   assign outs = {2'b00, ring2, aux2, battery_choice_out, aux_drive_out, ring_relay_drive,
                  test_relay_drive_one, test_relay_drive_two};
   // tag value is arbitrary
   line_ctrl_top #(.DEVICE_TAG(8'hC3)) DUT (.clk, .reset, .resetPin_n, .select_n, .bitClk,
      .serial_data_in, .serial_data_out, .serialDataOutOe, .serial_chain_out, .irqOut_n,
      .irqOe, .eventIn, .battery_choice_out, .aux_drive_out, .ring_relay_drive,
      .test_relay_drive_one, .test_relay_drive_two);
   // external-ringer build shares the port; only its aux and ring drivers are watched
   line_ctrl_top #(.RING_INTERNAL(1'b0)) DUT2 (.clk, .reset, .resetPin_n, .select_n,
      .bitClk, .serial_data_in, .serial_data_out(), .serialDataOutOe(), .serial_chain_out(),
      .irqOut_n(), .irqOe(), .eventIn, .battery_choice_out(), .aux_drive_out(aux2),
      .ring_relay_drive(ring2), .test_relay_drive_one(), .test_relay_drive_two());
   host_serial_model host (.clk, .dataOutPin, .chainPin(serial_chain_out), .select_n, .bitClk,
      .serial_data_in);
   always #20 clk = ~clk;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      host.frame(16, {1'b0, a, d, 8'h00});
   endtask
   task automatic rd(input logic [6:0] a);
      host.frame(16, {1'b1, a, 16'h0000});
      rdv = host.rdSeen;
   endtask
   task automatic t_reset;
      check(outs, 16'h0000);
      check({13'h0000, serial_chain_out, serialDataOutOe, irqWire}, 16'h0005);
   endtask
   task automatic t_drive;
      wr(ADDR_DRIVE_A, 8'h1F);
      wr(ADDR_DRIVE_B, 8'hE5);
      check(outs, 16'h3345);
      rd(ADDR_DRIVE_B);
      check({8'h00, rdv}, 16'h00E5);
      rd(ADDR_ID);
      check({8'h00, rdv}, 16'h00C3);
      rd(7'h7F);
      check({8'h00, rdv}, {8'h00, UNMAPPED_READ});
   endtask
   task automatic t_chain;
      host.frame(24, {1'b0, ADDR_MASK, 8'h00, 8'hA5});
      check({host.chainSeen[23:9], 1'b0}, 16'hFFFE);
      check({8'h00, host.chainSeen[7:0]}, 16'h00A5);
   endtask
   task automatic t_partial;
      host.frame(12, {1'b0, ADDR_DRIVE_A, 16'h0000});
      check(outs, 16'h3345);
      host.stray(16, {1'b0, ADDR_DRIVE_A, 16'h0000});
      check(outs, 16'h3345);
      check({14'h0000, serial_chain_out, serialDataOutOe}, 16'h0002);
   endtask
   task automatic t_irq;
      wr(ADDR_MASK, 8'h01);
      eventIn = 8'h02;
      @(negedge clk);
      eventIn = 8'h00;
      repeat (3) @(negedge clk);
      check({15'h0000, irqWire}, 16'h0001);
      eventIn = 8'h01;
      @(negedge clk);
      eventIn = 8'h00;
      repeat (3) @(negedge clk);
      check({15'h0000, irqWire}, 16'h0000);
      rd(ADDR_EVENTS);
      check({8'h00, rdv}, 16'h0001);
      wr(ADDR_PENDING, 8'h01);
      check({15'h0000, irqWire}, 16'h0001);
      rd(ADDR_PENDING);
      check({8'h00, rdv}, 16'h0002);
   endtask
   task automatic t_pin;
      resetPin_n = 1'b0;
      repeat (6) @(negedge clk);
      check(outs, 16'h0000);
      resetPin_n = 1'b1;
      repeat (5) @(negedge clk);
      rd(ADDR_DRIVE_B);
      check({8'h00, rdv}, {8'h00, DRIVE_RESET});
      rd(ADDR_MASK);
      check({8'h00, rdv}, {8'h00, MASK_RESET});
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      resetPin_n = 1'b1;
      eventIn = 8'h00;
      repeat (5) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      t_reset;
      t_drive;
      t_chain;
      t_partial;
      t_irq;
      t_pin;
      tally_and_finish;
   end
   // run needs a few thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      tally_and_finish;
   end
endmodule
